// ==== src/dmacr_pkg.sv ====
// constants, field layout and types shared by the dma channel files
// What this block does
// - circular mode, negative step below base wraps to the buffer maximum.
// - negative wrap lands at maximum minus the overshoot beyond base.
// - double-word mode doubles the step, so index two moves four.
// - reload enable set reloads channel context at each block completion.
// - reload copies the global source reload value into the source address.
// - reload copies the global destination reload value into the destination.
// - reload copies the global element count into the element counter.
// - reload copies the low byte of global frame count into frame counter.
// - upper byte of global frame count is ignored and reads zero.
// - reload happens only in multiframe mode, never in circular mode.
// - interrupt enable clear means no interrupt request at all.
// - circular, point select one: interrupt at half and full buffer.
// - multiframe, point select zero: interrupt only at block end.
// - multiframe, point select one: interrupt at each frame end and block end.
// - a frame ends when its count reaches zero.
// - a block ends only when element and frame counts are both zero.
// - circular interrupts compare the next address, not the current one.
// - positive step: half interrupt when next first reaches base plus half size.
// - negative step: half interrupt when next first drops below the half point.
// - full interrupt when next wraps to base, or to maximum when negative.
// - circular mode uses the element count as unsigned buffer size.
// - positive step past maximum wraps to base plus the overshoot.
// - double-word second address is the first with bit zero inverted.
package dmacr_pkg;
  localparam logic [7:0] OFF_MODE     = 8'h00;
  localparam logic [7:0] OFF_SRC      = 8'h04;
  localparam logic [7:0] OFF_DST      = 8'h08;
  localparam logic [7:0] OFF_CTR      = 8'h0C;
  localparam logic [7:0] OFF_FRM      = 8'h10;
  localparam logic [7:0] OFF_INDEX    = 8'h14;
  localparam logic [7:0] OFF_GSRC     = 8'h18;
  localparam logic [7:0] OFF_GDST     = 8'h1C;
  localparam logic [7:0] OFF_GCTR     = 8'h20;
  localparam logic [7:0] OFF_GFRM     = 8'h24;
  localparam logic [7:0] OFF_STATUS   = 8'h28;
  localparam int unsigned MODE_W      = 10;
  localparam int unsigned BIT_RELOAD  = 0;
  localparam int unsigned BIT_XMODE   = 1;
  localparam int unsigned BIT_IEN     = 2;
  localparam int unsigned BIT_IPT     = 3;
  localparam int unsigned SIDX_LSB    = 4;
  localparam int unsigned DIDX_LSB    = 6;
  localparam int unsigned BIT_DBL     = 8;
  localparam int unsigned BIT_EN      = 9;
  localparam int unsigned ST_ACTIVE   = 0;
  localparam int unsigned ST_HALF     = 1;
  localparam int unsigned ST_FULL     = 2;
  localparam int unsigned ST_FRAME    = 3;
  localparam int unsigned ST_BLOCK    = 4;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [15:0] RST_WORD    = 16'h0000;
  typedef enum logic [1:0] {IDX_NONE, IDX_INC, IDX_DEC, IDX_OFS} dmacr_idx_t;

  // byte-enable merge for a 16-bit register held in the low half of a word
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = wd[7:0];
    if (strb[1]) r[15:8] = wd[15:8];
    return r;
  endfunction
endpackage

// ==== src/dmacr_wrap_if.sv ====
// carrier between the channel and its circular address calculator
`timescale 1ns/1ps
interface dmacr_wrap_if;
  logic [15:0]        cur;
  logic signed [17:0] step;
  logic [15:0]        size;
  logic [15:0]        next;
  logic               wrapped;
  logic               halfCross;
  modport calc (input cur, input step, input size, output next, output wrapped,
                output halfCross);
  modport user (output cur, output step, output size, input next, input wrapped,
                input halfCross);
endinterface

// ==== src/dmacr_wrap_calc.sv ====
// circular buffer next address, wrap and half-point detection
`timescale 1ns/1ps
module dmacr_wrap_calc (
  dmacr_wrap_if.calc w
);
  // base alignment is the power of two above the size msb
  function automatic logic [15:0] smear(input logic [15:0] v);
    logic [15:0] m;
    m = v;
    for (int i = 0; i < 4; i++) m = m | (m >> (1 << i));
    return m;
  endfunction

  logic [15:0]        base;
  logic signed [17:0] baseS, sizeS, maxS, halfS, curS, sumS, nextS;
  logic               neg;

  always_comb begin
    base  = w.cur & ~smear(w.size);
    baseS = signed'({2'b00, base});
    sizeS = signed'({2'b00, w.size});
    curS  = signed'({2'b00, w.cur});
    maxS  = baseS + sizeS - 18'sd1;
    halfS = baseS + signed'({3'b000, w.size[15:1]});
    sumS  = curS + w.step;
    neg   = w.step < 18'sd0;
    w.wrapped = neg ? (sumS < baseS) : (sumS > maxS);
    if (w.wrapped) begin
      nextS = neg ? sumS + sizeS : sumS - sizeS;
    end else begin
      nextS = sumS;
    end
    if (neg) begin
      w.halfCross = !w.wrapped && curS >= halfS && nextS < halfS;
    end else begin
      w.halfCross = !w.wrapped && curS < halfS && nextS >= halfS;
    end
    w.next = nextS[15:0];
  end
endmodule

// ==== src/dmacr_irq_gen.sv ====
// interrupt point selection and single-cycle request pulse
`timescale 1ns/1ps
module dmacr_irq_gen (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic irqEnable,
  input  wire logic pointSel,
  input  wire logic circular,
  input  wire logic accessDone,
  input  wire logic wrapped,
  input  wire logic halfCross,
  input  wire logic frameEnd,
  input  wire logic blockEnd,
  output logic      irqReq
);
  logic hit;

  always_comb begin
    if (circular) begin
      hit = wrapped || (pointSel && halfCross);
    end else begin
      hit = blockEnd || (pointSel && frameEnd);
    end
  end

  // one pulse per access, so a crossing cannot raise two requests
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      irqReq <= 1'b0;
    end else begin
      irqReq <= accessDone && irqEnable && hit;
    end
  end
endmodule

// ==== src/dmacr_channel.sv ====
// dma channel: axi4-lite registers, address stepping, reload and events
`timescale 1ns/1ps
module dmacr_channel #(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              accessDone,
  output logic [15:0]            srcAddr,
  output logic [15:0]            srcAddr2,
  output logic [15:0]            dstAddr,
  output logic [15:0]            dstAddr2,
  output logic                   channelActive,
  output logic                   blockDone,
  output logic                   irqReq
);
  if (ADDR_W < 6 || ADDR_W > 8) begin : g_bad_addr_w
    $error("ADDR_W must be 6 to 8");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register state

  logic [dmacr_pkg::MODE_W-1:0] modeCtl;
  logic [15:0]                  elemCtr;
  logic [7:0]                   frameCtr;
  logic [15:0]                  indexReg;
  logic [15:0]                  gSrc;
  logic [15:0]                  gDst;
  logic [15:0]                  gCtr;
  logic [7:0]                   gFrm;
  logic [4:1]                   stickyEv;

  logic [7:0]                   wrAddr;
  logic [31:0]                  wrData;
  logic [3:0]                   wrStrb;
  logic                         awHeld;
  logic                         wHeld;
  logic                         wrFire;

  logic [15:0]                  next_srcAddr;
  logic [15:0]                  next_dstAddr;
  logic [15:0]                  next_elemCtr;
  logic [7:0]                   next_frameCtr;

  ////////////////////////////////////////////////////////////////////////////////
  // decoded control fields

  logic                  reloadEn;
  logic                  circular;
  logic                  irqEnable;
  logic                  pointSel;
  logic                  dblWord;
  dmacr_pkg::dmacr_idx_t srcIdx;
  dmacr_pkg::dmacr_idx_t dstIdx;
  logic                  srcCirc;
  logic                  access;
  logic                  frameEnd;
  logic                  blockEnd;
  logic                  doReload;
  logic signed [17:0]    srcStep;
  logic signed [17:0]    dstStep;

  assign reloadEn  = modeCtl[dmacr_pkg::BIT_RELOAD];
  assign circular  = modeCtl[dmacr_pkg::BIT_XMODE];
  assign irqEnable = modeCtl[dmacr_pkg::BIT_IEN];
  assign pointSel  = modeCtl[dmacr_pkg::BIT_IPT];
  assign dblWord   = modeCtl[dmacr_pkg::BIT_DBL];
  assign srcIdx    = dmacr_pkg::dmacr_idx_t'(modeCtl[dmacr_pkg::SIDX_LSB +: 2]);
  assign dstIdx    = dmacr_pkg::dmacr_idx_t'(modeCtl[dmacr_pkg::DIDX_LSB +: 2]);
  assign channelActive = modeCtl[dmacr_pkg::BIT_EN];

  // accesses reported while the channel is off are ignored
  assign access = accessDone && channelActive;

  // signed step of one side; double-word mode doubles whatever the mode gives
  function automatic logic signed [17:0] stepOf(input dmacr_pkg::dmacr_idx_t m,
                                                 input logic [15:0] idx, input logic dbl);
    logic signed [17:0] s;
    case (m)
      dmacr_pkg::IDX_INC: s = 18'sd1;
      dmacr_pkg::IDX_DEC: s = -18'sd1;
      dmacr_pkg::IDX_OFS: s = 18'(signed'(idx));
      default:            s = 18'sd0;
    endcase
    if (dbl) s = s <<< 1;
    return s;
  endfunction

  assign srcStep = stepOf(srcIdx, indexReg, dblWord);
  assign dstStep = stepOf(dstIdx, indexReg, dblWord);

  // only one side may step in circular mode; the stepping side owns the buffer
  assign srcCirc = (srcIdx != dmacr_pkg::IDX_NONE);

  ////////////////////////////////////////////////////////////////////////////////
  // circular address calculation

  dmacr_wrap_if wif ();

  assign wif.cur  = srcCirc ? srcAddr : dstAddr;
  assign wif.step = srcCirc ? srcStep : dstStep;
  assign wif.size = elemCtr;

  dmacr_wrap_calc u_wrap (
    .w (wif.calc)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // frame and block bookkeeping (multiframe only)

  // a counter at zero on entry is treated as a last element, never an underflow
  assign frameEnd = access && !circular && (elemCtr <= 16'h0001);
  assign blockEnd = frameEnd && (frameCtr == 8'h00);
  assign doReload = blockEnd && reloadEn && !circular;

  always_comb begin
    next_elemCtr  = elemCtr;
    next_frameCtr = frameCtr;
    if (doReload) begin
      next_elemCtr  = gCtr;
      next_frameCtr = gFrm;
    end else if (blockEnd) begin
      next_elemCtr  = 16'h0000;
    end else if (frameEnd) begin
      next_elemCtr  = gCtr;
      next_frameCtr = frameCtr - 8'h01;
    end else if (access && !circular) begin
      next_elemCtr  = elemCtr - 16'h0001;
    end
    if (wrFire && wrAddr == dmacr_pkg::OFF_CTR) begin
      next_elemCtr = dmacr_pkg::merge16(elemCtr, wrData, wrStrb);
    end
    if (wrFire && wrAddr == dmacr_pkg::OFF_FRM && wrStrb[0]) begin
      next_frameCtr = wrData[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // address stepping

  always_comb begin
    next_srcAddr = srcAddr;
    next_dstAddr = dstAddr;
    if (doReload) begin
      next_srcAddr = gSrc;
      next_dstAddr = gDst;
    end else if (access) begin
      if (circular && srcCirc) begin
        next_srcAddr = wif.next;
      end else begin
        next_srcAddr = srcAddr + srcStep[15:0];
      end
      if (circular && !srcCirc) begin
        next_dstAddr = wif.next;
      end else begin
        next_dstAddr = dstAddr + dstStep[15:0];
      end
    end
    if (wrFire && wrAddr == dmacr_pkg::OFF_SRC) begin
      next_srcAddr = dmacr_pkg::merge16(srcAddr, wrData, wrStrb);
    end
    if (wrFire && wrAddr == dmacr_pkg::OFF_DST) begin
      next_dstAddr = dmacr_pkg::merge16(dstAddr, wrData, wrStrb);
    end
  end

  // the second word is always the first with bit zero flipped; wrap ignores it
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      srcAddr  <= dmacr_pkg::RST_WORD;
      dstAddr  <= dmacr_pkg::RST_WORD;
      srcAddr2 <= 16'h0001;
      dstAddr2 <= 16'h0001;
    end else begin
      srcAddr  <= next_srcAddr;
      dstAddr  <= next_dstAddr;
      srcAddr2 <= next_srcAddr ^ 16'h0001;
      dstAddr2 <= next_dstAddr ^ 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      elemCtr  <= dmacr_pkg::RST_WORD;
      frameCtr <= 8'h00;
    end else begin
      elemCtr  <= next_elemCtr;
      frameCtr <= next_frameCtr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control and reload registers

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      modeCtl <= '0;
    end else if (wrFire && wrAddr == dmacr_pkg::OFF_MODE) begin
      if (wrStrb[0]) modeCtl[7:0] <= wrData[7:0];
      if (wrStrb[1]) modeCtl[dmacr_pkg::MODE_W-1:8] <= wrData[dmacr_pkg::MODE_W-1:8];
    end else if (blockEnd && !doReload) begin
      // without reload the channel stops itself at block end
      modeCtl[dmacr_pkg::BIT_EN] <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      indexReg <= dmacr_pkg::RST_WORD;
      gSrc     <= dmacr_pkg::RST_WORD;
      gDst     <= dmacr_pkg::RST_WORD;
      gCtr     <= dmacr_pkg::RST_WORD;
      gFrm     <= 8'h00;
    end else if (wrFire) begin
      case (wrAddr)
        dmacr_pkg::OFF_INDEX: indexReg <= dmacr_pkg::merge16(indexReg, wrData, wrStrb);
        dmacr_pkg::OFF_GSRC:  gSrc     <= dmacr_pkg::merge16(gSrc, wrData, wrStrb);
        dmacr_pkg::OFF_GDST:  gDst     <= dmacr_pkg::merge16(gDst, wrData, wrStrb);
        dmacr_pkg::OFF_GCTR:  gCtr     <= dmacr_pkg::merge16(gCtr, wrData, wrStrb);
        dmacr_pkg::OFF_GFRM: begin
          if (wrStrb[0]) gFrm <= wrData[7:0];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // event flags and outputs

  logic [4:1] evSet;
  logic [4:1] evClr;

  assign evSet[dmacr_pkg::ST_HALF]  = access && circular && wif.halfCross;
  assign evSet[dmacr_pkg::ST_FULL]  = access && circular && wif.wrapped;
  assign evSet[dmacr_pkg::ST_FRAME] = frameEnd;
  assign evSet[dmacr_pkg::ST_BLOCK] = blockEnd;
  assign evClr = (wrFire && wrAddr == dmacr_pkg::OFF_STATUS && wrStrb[0]) ?
                 wrData[4:1] : 4'h0;

  // an event in the clearing cycle survives the clear
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stickyEv <= 4'h0;
    end else begin
      stickyEv <= (stickyEv & ~evClr) | evSet;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      blockDone <= 1'b0;
    end else begin
      blockDone <= blockEnd;
    end
  end

  // cpu-side masking of this request is left to the interrupt controller
  dmacr_irq_gen u_irq (
    .ref_clk    (ref_clk),
    .srst       (srst),
    .irqEnable  (irqEnable),
    .pointSel   (pointSel),
    .circular   (circular),
    .accessDone (access),
    .wrapped    (wif.wrapped),
    .halfCross  (wif.halfCross),
    .frameEnd   (frameEnd),
    .blockEnd   (blockEnd),
    .irqReq     (irqReq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel

  function automatic logic mapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= dmacr_pkg::OFF_STATUS;
  endfunction

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld && !s_axi_bvalid;
  assign wrFire        = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      awHeld <= 1'b0;
      wrAddr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awHeld <= 1'b1;
      wrAddr <= 8'(s_axi_awaddr);
    end else if (wrFire) begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wHeld  <= 1'b0;
      wrData <= 32'h0000_0000;
      wrStrb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wHeld  <= 1'b1;
      wrData <= s_axi_wdata;
      wrStrb <= s_axi_wstrb;
    end else if (wrFire) begin
      wHeld  <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= dmacr_pkg::RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(wrAddr) ? dmacr_pkg::RESP_OKAY : dmacr_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel

  logic [7:0]  rdAddr;
  logic [31:0] rdWord;

  assign rdAddr        = 8'(s_axi_araddr);
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rdWord = 32'h0000_0000;
    case (rdAddr)
      dmacr_pkg::OFF_MODE:   rdWord[dmacr_pkg::MODE_W-1:0] = modeCtl;
      dmacr_pkg::OFF_SRC:    rdWord[15:0] = srcAddr;
      dmacr_pkg::OFF_DST:    rdWord[15:0] = dstAddr;
      dmacr_pkg::OFF_CTR:    rdWord[15:0] = elemCtr;
      dmacr_pkg::OFF_FRM:    rdWord[7:0]  = frameCtr;
      dmacr_pkg::OFF_INDEX:  rdWord[15:0] = indexReg;
      dmacr_pkg::OFF_GSRC:   rdWord[15:0] = gSrc;
      dmacr_pkg::OFF_GDST:   rdWord[15:0] = gDst;
      dmacr_pkg::OFF_GCTR:   rdWord[15:0] = gCtr;
      dmacr_pkg::OFF_GFRM:   rdWord[15:0] = {8'h00, gFrm};
      dmacr_pkg::OFF_STATUS: rdWord[4:0]  = {stickyEv, channelActive};
      default:               rdWord = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= dmacr_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdWord;
      s_axi_rresp  <= mapped(rdAddr) ? dmacr_pkg::RESP_OKAY : dmacr_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ==== tb/dmacr_datapath_model.sv ====
// far-side datapath model: one access strobe per element moved
`timescale 1ns/1ps
module dmacr_datapath_model (
  input  wire logic ref_clk,
  output logic      accessDone
);
  initial accessDone = 1'h0;
  // memory may stall; at least one idle edge keeps strobes apart
  task automatic access(input int stall);
    repeat (stall + 1) @(posedge ref_clk);
    accessDone <= 1'h1;
    @(posedge ref_clk);
    accessDone <= 1'h0;
  endtask
endmodule

// ==== tb/dmacr_channel_chk.sv ====
// checker: event pulses, address pairing and bus answers
`timescale 1ns/1ps
module dmacr_channel_chk (
  input wire logic        ref_clk,
  input wire logic        srst,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        accessDone,
  input wire logic        channelActive,
  input wire logic [15:0] srcAddr,
  input wire logic [15:0] srcAddr2,
  input wire logic [15:0] dstAddr,
  input wire logic [15:0] dstAddr2,
  input wire logic        blockDone,
  input wire logic        irqReq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////
  irq_pulse_a: assert property (irqReq |=> !irqReq)
    else $error("irq request longer than one cycle");
  blk_pulse_a: assert property (blockDone |=> !blockDone)
    else $error("block done longer than one cycle");
  irq_cause_a: assert property (irqReq |-> $past(accessDone && channelActive))
    else $error("irq request without an access");
  blk_cause_a: assert property (blockDone |-> $past(accessDone && channelActive))
    else $error("block done without an access");
  src_pair_a: assert property (srcAddr2 == {srcAddr[15:1], !srcAddr[0]})
    else $error("second source address wrong");
  dst_pair_a: assert property (dstAddr2 == {dstAddr[15:1], !dstAddr[0]})
    else $error("second destination address wrong");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  irq_seen_c: cover property (irqReq);
  blk_seen_c: cover property (blockDone);
  err_seen_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind dmacr_channel dmacr_channel_chk chk_i (.ref_clk, .srst, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .accessDone, .channelActive,
  .srcAddr, .srcAddr2, .dstAddr, .dstAddr2, .blockDone, .irqReq);

// ==== tb/tb.sv ====
// top testbench: register bus, circular stepping and block reload
`timescale 1ns/1ps
module tb;
  logic        ref_clk = 1'h0;
  logic        srst = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0;
  logic        s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         accessDone, channelActive, blockDone, irqReq;
  wire [1:0]   s_axi_bresp, s_axi_rresp;
  wire [31:0]  s_axi_rdata;
  wire [15:0]  srcAddr, srcAddr2, dstAddr, dstAddr2;
  int          nFail = 0;
  int          numChecks = 0;
  always #2 ref_clk = ~ref_clk;
  dmacr_channel dmacr_channel_i (.*);
  dmacr_datapath_model dmacr_datapath_model_i (.ref_clk, .accessDone);
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    numChecks++;
    if (g !== e) begin
      nFail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic testDone;
    if (nFail == 0 && numChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ready seen at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ga, gw, gb;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(negedge ref_clk);
      ga = s_axi_awready && s_axi_awvalid;
      gw = s_axi_wready && s_axi_wvalid;
      gb = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge ref_clk);
      if (ga) s_axi_awvalid <= 1'h0;
      if (gw) s_axi_wvalid <= 1'h0;
      // once raised, bready stays up until the answer is taken
      s_axi_bready <= gb ? 1'h0 : (s_axi_bready | 1'($urandom));
    end while (!gb);
    chk(r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ga, gv;
    logic [31:0] x;
    logic [1:0] r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(negedge ref_clk);
      ga = s_axi_arready && s_axi_arvalid;
      gv = s_axi_rvalid && s_axi_rready;
      x = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk);
      if (ga) s_axi_arvalid <= 1'h0;
      s_axi_rready <= gv ? 1'h0 : (s_axi_rready | 1'($urandom));
    end while (!gv);
    chk(x, d);
    chk(r, e);
  endtask
  // circular step: {wrap, half crossing, next address}
  function automatic logic [17:0] nx(input int c, input int s, input int st);
    int m, b, h, n;
    logic w;
    m = 1;
    while (m < s) m = m * 2 + 1;
    b = c & ~m;
    h = b + s / 2;
    n = c + st;
    w = (st > 0) ? (n > b + s - 1) : (n < b);
    if (w) n = (st > 0) ? n - s : n + s;
    return {w, !w && ((st > 0) ? (c < h && n >= h) : (c >= h && n < h)), 16'(n)};
  endfunction
  initial begin
    #300000;
    nFail++;
    testDone;
  end
  initial begin
    logic [17:0] r;
    logic [15:0] sz, cur;
    logic [1:0]  sm;
    logic        db, ie, ip, rl;
    int          ix, st;
    void'($urandom(32'h0000_1ccf));
    repeat (16) @(posedge ref_clk);
    srst <= 1'h0;
    @(posedge ref_clk);
    wr(8'h18, 32'h0000_1000, 2'h0);
    wr(8'h1c, 32'h0000_2000, 2'h0);
    wr(8'h20, 32'h0000_0002, 2'h0);
    wr(8'h24, 32'h0000_1202, 2'h0);
    rd(8'h24, 32'h0000_0002, 2'h0);
    // two frames of two elements; the third pass runs without reload
    for (int p = 0; p < 3; p++) begin
      wr(8'h04, 32'h0000_0100, 2'h0);
      wr(8'h08, 32'h0000_0200, 2'h0);
      wr(8'h0c, 32'h0000_0002, 2'h0);
      wr(8'h10, 32'h0000_0001, 2'h0);
      wr(8'h00, p == 0 ? 32'h0000_025d : p == 1 ? 32'h0000_0255 : 32'h0000_0254, 2'h0);
      for (int k = 1; k < 5; k++) begin
        dmacr_datapath_model_i.access($urandom % 3);
        #1;
        chk(irqReq, k == 4 || (p == 0 && k == 2));
        chk(blockDone, k == 4);
        chk(srcAddr, k == 4 && p < 2 ? 16'h1000 : 16'h0100 + k);
        chk(dstAddr, k == 4 && p < 2 ? 16'h2000 : 16'h0200 + k);
      end
      chk(channelActive, p < 2);
      rd(8'h0c, p < 2 ? 32'h0000_0002 : 32'h0000_0000, 2'h0);
      rd(8'h10, p < 2 ? 32'h0000_0002 : 32'h0000_0000, 2'h0);
    end
    rd(8'h28, 32'h0000_0018, 2'h0);
    wr(8'h28, 32'h0000_001e, 2'h0);
    rd(8'h28, 32'h0000_0000, 2'h0);
    for (int t = 0; t < 6; t++) begin
      sz = 16'h0008 + 16'($urandom % 40);
      cur = 16'($urandom % 1000) * 16'h0040 + 16'($urandom) % sz;
      ix = 1 + $urandom % 3;
      if ($urandom % 2) ix = -ix;
      sm = 2'(1 + $urandom % 3);
      {db, ie, ip, rl} = 4'($urandom);
      // buffer 0580h..059eh stepped by twice two from its top
      if (t == 0) begin
        sz = 16'h001f;
        cur = 16'h059e;
        ix = 2;
        sm = 2'h3;
        {db, ie, ip} = 3'h7;
      end
      st = (sm == 2'h1) ? 1 : (sm == 2'h2) ? -1 : ix;
      if (db) st = st * 2;
      wr(8'h0c, 32'(sz), 2'h0);
      wr(8'h04, 32'(cur), 2'h0);
      wr(8'h08, 32'h0000_0055, 2'h0);
      wr(8'h14, 32'(ix), 2'h0);
      wr(8'h00, 32'({1'h1, db, 2'h0, sm, ip, ie, 1'h1, rl}), 2'h0);
      repeat (2 * sz) begin
        r = nx(cur, sz, st);
        dmacr_datapath_model_i.access($urandom % 3);
        #1;
        chk(srcAddr, r[15:0]);
        chk(srcAddr2, r[15:0] ^ 16'h0001);
        chk(dstAddr, 16'h0055);
        chk(irqReq, ie & (r[17] | ip & r[16]));
        cur = r[15:0];
      end
    end
    wr(8'h2c, 32'h0000_ffff, 2'h2);
    rd(8'h2c, 32'h0000_0000, 2'h2);
    testDone;
  end
endmodule
